// ### dmcr_consts.svh
// Register offsets, field positions and reset values of the mode control bank.
// Included by the bank, the ramp keyer and the bench; holds definitions only.
`ifndef DMCR_CONSTS_SVH
`define DMCR_CONSTS_SVH
`define DMCR_ADDR_CTRL      8'h00
`define DMCR_ADDR_AMP       8'h02
`define DMCR_ADDR_ARR       8'h03
`define DMCR_ADDR_FTW0      8'h04
`define DMCR_ADDR_PHS0      8'h05
`define DMCR_ADDR_TUN1      8'h06
`define DMCR_ADDR_FALL      8'h07
`define DMCR_ADDR_RISE      8'h08
`define DMCR_BIT_RAM_EN     31
`define DMCR_BIT_RAM_DEST   30
`define DMCR_PROF_HI        29
`define DMCR_PROF_LO        27
`define DMCR_BIT_ARR_LOAD   26
`define DMCR_BIT_KEY_EN     25
`define DMCR_BIT_KEY_AUTO   24
`define DMCR_BIT_ASYNC      23
`define DMCR_BIT_SWEEP      21
`define DMCR_CTRL_RESET     32'h00000000
`define DMCR_POW_RESET      16'h0000
`define DMCR_POW_MASK       16'h3fff
`define DMCR_WORD_RESET     40'h0000000000
`endif

// ### dmcr_host_model.sv
// Host side of the register port: writes, update strobes and reads.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps
module dmcr_host_model (
    input  wire logic         sys_clk,
    output logic [7:0]        regAddr,
    output logic [39:0]       regWrData,
    output logic              regWrEn,
    output logic              updateStrobe,
    input  wire logic [39:0]  regRdData
);
    initial begin
        regAddr = 8'h00;
        regWrData = 40'h0000000000;
        regWrEn = 1'b0;
        updateStrobe = 1'b0;
    end
    // Data is scrambled after each write so that nothing latches a stale bus value.
    task automatic wr(input logic [7:0] a, input logic [39:0] d);
        @(posedge sys_clk);
        #1;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge sys_clk);
        #1;
        regWrEn = 1'b0;
        regWrData = ~d;
    endtask
    task automatic upd();
        @(posedge sys_clk);
        #1;
        updateStrobe = 1'b1;
        @(posedge sys_clk);
        #1;
        updateStrobe = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [39:0] d);
        @(posedge sys_clk);
        #1;
        regAddr = a;
        @(posedge sys_clk);
        #1;
        d = regRdData;
    endtask
endmodule

// ### dmcr_mode_control.sv
// Mode control register bank of the synthesizer: control word and tuning words.
// Assumes a serial-port front end delivering decoded address, data and strobes.
//
// How it works
// - With the RAM enable bit low the RAM is idle and tone or sweep mode runs.
// - With the RAM enable bit high the RAM runs under the current profile's segment word.
// - With the RAM on, the destination bit routes RAM data to frequency or phase.
// - With the RAM on and an internal profile code set, external selects are ignored.
// - With the load bit low the ramp timer reloads only on timeout.
// - With the load bit high the ramp timer also reloads on each update strobe.
// - Keying is bypassed when its enable is low; the auto bit picks its form.
// - Manual keying scales every sample by the amplitude scale value.
// - Auto keying ramps the scalar up to the scale value while the key pin is high.
// - Auto keying ramps the scalar down to zero while the key pin is low.
// - The automatic sync bit aligns the sync clock to the sync input.
// - Phase offset word zero at 0x05 holds 14 bits, upper two bits read zero.
// - The rising sweep word at 0x08 holds a 32-bit delta and an 8-bit rate.
// - With sweep on, profile select zero picks the rising or falling delta.
// - The control register sits at 0x00 and resets to all zero.
`timescale 1ns/1ps
`include "dmcr_consts.svh"
module dmcr_mode_control (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         clkEn,
    input  wire logic [7:0]   regAddr,
    input  wire logic [39:0]  regWrData,
    input  wire logic         regWrEn,
    input  wire logic         updateStrobe,
    output logic [39:0]       regRdData,
    input  wire logic [2:0]   profileSelect,
    input  wire logic         keyingInputPin,
    input  wire logic         syncIn,
    input  wire logic [13:0]  outputAmplitudeScale,
    input  wire logic [7:0]   ampRampRate,
    input  wire logic [13:0]  ramSegmentControlWord,
    output logic              ramActive,
    output logic              ramToPhase,
    output logic              ramToFrequency,
    output logic [1:0]        activeProfile,
    output logic [13:0]       outputScalar,
    output logic              rampTick,
    output logic              syncAlignEnable,
    output logic              syncAlignReq,
    output logic              sweepActive,
    output logic [31:0]       sweepDelta,
    output logic [7:0]        sweepRate,
    output logic [15:0]       phaseOffsetWord,
    output logic [31:0]       tuningWordOne,
    output logic [1:0]        ramMode
);
    logic [31:0] shadowCtrl;
    logic [31:0] controlFunctionFirst;
    logic [15:0] shadowPow;
    logic [31:0] shadowFtw;
    logic [39:0] shadowFall;
    logic [39:0] shadowRise;
    logic [39:0] fallingSweepControlWord;
    logic [39:0] risingSweepControlWord;
    logic [1:0]  profileStep;
    logic        syncSeen;
    dmcr_pkg::dmcr_key_t keyMode;
    dmcr_pkg::dmcr_src_t srcMode;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
        hit = regWrEn && (a == ref_addr);
    endfunction

    // Writes land in shadow copies; the update strobe commits them together so
    // a multi-register change never takes effect half applied.
    // control reset zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shadowCtrl <= `DMCR_CTRL_RESET;
            shadowPow  <= `DMCR_POW_RESET;
            shadowFtw  <= 32'h00000000;
            shadowFall <= `DMCR_WORD_RESET;
            shadowRise <= `DMCR_WORD_RESET;
        end else if (clkEn) begin
            if (hit(regAddr, `DMCR_ADDR_CTRL)) shadowCtrl <= regWrData[31:0];
            if (hit(regAddr, `DMCR_ADDR_PHS0)) shadowPow <= regWrData[15:0] & `DMCR_POW_MASK;
            if (hit(regAddr, `DMCR_ADDR_TUN1)) shadowFtw <= regWrData[31:0];
            if (hit(regAddr, `DMCR_ADDR_FALL)) shadowFall <= regWrData;
            if (hit(regAddr, `DMCR_ADDR_RISE)) shadowRise <= regWrData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            controlFunctionFirst    <= `DMCR_CTRL_RESET;
            phaseOffsetWord         <= `DMCR_POW_RESET;
            tuningWordOne           <= 32'h00000000;
            fallingSweepControlWord <= `DMCR_WORD_RESET;
            risingSweepControlWord  <= `DMCR_WORD_RESET;
        end else if (clkEn && updateStrobe) begin
            controlFunctionFirst    <= shadowCtrl;
            phaseOffsetWord         <= shadowPow;
            tuningWordOne           <= shadowFtw;
            fallingSweepControlWord <= shadowFall;
            risingSweepControlWord  <= shadowRise;
        end
    end

    // Reads return the shadow so software sees what it last wrote.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regRdData <= 40'h0000000000;
        end else if (clkEn) begin
            case (regAddr)
                `DMCR_ADDR_CTRL: regRdData <= {8'h00, shadowCtrl};
                `DMCR_ADDR_PHS0: regRdData <= {24'h000000, shadowPow};
                `DMCR_ADDR_TUN1: regRdData <= {8'h00, shadowFtw};
                `DMCR_ADDR_FALL: regRdData <= shadowFall;
                `DMCR_ADDR_RISE: regRdData <= shadowRise;
                default:         regRdData <= 40'h0000000000;
            endcase
        end
    end

    always_comb begin
        srcMode = controlFunctionFirst[`DMCR_BIT_RAM_EN] ? dmcr_pkg::DMCR_SRC_RAM
                                                         : dmcr_pkg::DMCR_SRC_TONE;
        ramActive = (srcMode == dmcr_pkg::DMCR_SRC_RAM);
        ramMode = ramActive ? ramSegmentControlWord[1:0] : 2'b00;
    end

    assign ramToPhase     = ramActive && controlFunctionFirst[`DMCR_BIT_RAM_DEST];
    assign ramToFrequency = ramActive && !controlFunctionFirst[`DMCR_BIT_RAM_DEST];

    // The internal loop steps one profile per ramp tick; a coarse trade-off that
    // keeps the loop cheap rather than honouring per-profile dwell times.
    // internal profile loop
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            profileStep <= 2'b00;
        end else if (clkEn) begin
            if (ramActive && controlFunctionFirst[`DMCR_PROF_HI:`DMCR_PROF_LO] != 3'b000) begin
                if (rampTick) profileStep <= profileStep + 2'b01;
            end else begin
                profileStep <= 2'b00;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            activeProfile <= 2'b00;
        end else if (clkEn) begin
            if (ramActive && controlFunctionFirst[`DMCR_PROF_HI:`DMCR_PROF_LO] != 3'b000) begin
                activeProfile <= profileStep;
            end else begin
                activeProfile <= profileSelect[1:0];
            end
        end
    end

    always_comb begin
        if (!controlFunctionFirst[`DMCR_BIT_KEY_EN]) begin
            keyMode = dmcr_pkg::DMCR_KEY_OFF;
        end else if (controlFunctionFirst[`DMCR_BIT_KEY_AUTO]) begin
            keyMode = dmcr_pkg::DMCR_KEY_AUTO;
        end else begin
            keyMode = dmcr_pkg::DMCR_KEY_MANUAL;
        end
    end

    dmcr_ramp_keyer keyer (
        .sys_clk              (sys_clk),
        .rst                  (rst),
        .clkEn                (clkEn),
        .keyMode              (keyMode),
        .reloadOnUpdate       (controlFunctionFirst[`DMCR_BIT_ARR_LOAD]),
        .updateStrobe         (updateStrobe),
        .keyingInputPin       (keyingInputPin),
        .outputAmplitudeScale (outputAmplitudeScale),
        .rampRate             (ampRampRate),
        .outputScalar         (outputScalar),
        .rampTick             (rampTick)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            syncSeen     <= 1'b0;
            syncAlignReq <= 1'b0;
        end else if (clkEn) begin
            syncSeen     <= syncIn;
            syncAlignReq <= controlFunctionFirst[`DMCR_BIT_ASYNC] && syncIn && !syncSeen;
        end
    end
    assign syncAlignEnable = controlFunctionFirst[`DMCR_BIT_ASYNC];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sweepDelta <= 32'h00000000;
            sweepRate  <= 8'h00;
        end else if (clkEn) begin
            if (profileSelect[0]) begin
                sweepDelta <= risingSweepControlWord[31:0];
                sweepRate  <= risingSweepControlWord[39:32];
            end else begin
                sweepDelta <= fallingSweepControlWord[31:0];
                sweepRate  <= fallingSweepControlWord[39:32];
            end
        end
    end
    assign sweepActive = !ramActive && controlFunctionFirst[`DMCR_BIT_SWEEP];

    sequence s_write_ctrl;
        clkEn && regWrEn && (regAddr == `DMCR_ADDR_CTRL) && !updateStrobe;
    endsequence
    sequence s_commit;
        clkEn && updateStrobe;
    endsequence
    property p_commit_ctrl;
        @(posedge sys_clk) disable iff (rst)
        s_write_ctrl ##[1:2] s_commit |=> controlFunctionFirst == $past(shadowCtrl);
    endproperty
    a_commit_ctrl: assert property (p_commit_ctrl) else $error("control not committed");
    property p_ram_off;
        @(posedge sys_clk) disable iff (rst)
        !controlFunctionFirst[`DMCR_BIT_RAM_EN] |-> !ramToPhase && !ramToFrequency;
    endproperty
    a_ram_off: assert property (p_ram_off) else $error("RAM routed while off");
    property p_ram_dest;
        @(posedge sys_clk) disable iff (rst)
        ramActive |-> (ramToPhase == controlFunctionFirst[`DMCR_BIT_RAM_DEST]);
    endproperty
    a_ram_dest: assert property (p_ram_dest) else $error("wrong RAM route");
    property p_pow_top;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |-> phaseOffsetWord[15:14] == 2'b00;
    endproperty
    a_pow_top: assert property (p_pow_top) else $error("phase word top bits set");
    property p_sweep_dir;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && profileSelect[0]) |=> sweepDelta == $past(risingSweepControlWord[31:0]);
    endproperty
    a_sweep_dir: assert property (p_sweep_dir) else $error("wrong sweep delta");
    property p_ext_profile;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && !ramActive) |=> activeProfile == $past(profileSelect[1:0]);
    endproperty
    a_ext_profile: assert property (p_ext_profile) else $error("profile not followed");
    property p_manual_scale;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && keyMode == dmcr_pkg::DMCR_KEY_MANUAL) |=>
            outputScalar == $past(outputAmplitudeScale);
    endproperty
    a_manual_scale: assert property (p_manual_scale) else $error("manual scale wrong");
    property p_key_off;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && keyMode == dmcr_pkg::DMCR_KEY_OFF) |=> outputScalar == 14'h3fff;
    endproperty
    a_key_off: assert property (p_key_off) else $error("keying not bypassed");
    property p_sync_req;
        @(posedge sys_clk) disable iff (rst)
        syncAlignReq |-> $past(controlFunctionFirst[`DMCR_BIT_ASYNC]);
    endproperty
    a_sync_req: assert property (p_sync_req) else $error("sync while disabled");
endmodule

// ### dmcr_mode_control_tb_top.sv
// Self-checking bench of the mode control bank with a host model on its register port.
// Assumes the design and its constants header are compiled before it.
`timescale 1ns/1ps
`include "dmcr_consts.svh"
module dmcr_mode_control_tb_top;
    logic sys_clk, rst, keyingInputPin, syncIn, clkEn;
    logic [2:0] profileSelect;
    logic [13:0] outputAmplitudeScale, ramSegmentControlWord;
    logic [7:0] ampRampRate, regAddr;
    logic [39:0] regWrData, regRdData, rdv;
    logic regWrEn, updateStrobe, ramActive, ramToPhase, ramToFrequency, rampTick;
    logic syncAlignEnable, syncAlignReq, sweepActive;
    logic [1:0] activeProfile, ramMode;
    logic [13:0] outputScalar;
    logic [31:0] sweepDelta, tuningWordOne;
    logic [7:0] sweepRate;
    logic [15:0] phaseOffsetWord;
    int err_total = 0, n_compared = 0, ticks = 0, syncs = 0;
    logic [31:0] rowCtrl [5] = '{32'h00000000, 32'h80000000, 32'hc0000000,
                                 32'h40000000, 32'h00a00000};
    logic [6:0] rowExp [5] = '{7'b0000000, 7'b1010010, 7'b1100010, 7'b0000000, 7'b0001100};

    dmcr_host_model i_host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .updateStrobe(updateStrobe), .regRdData(regRdData));
    dmcr_mode_control i_dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .updateStrobe(updateStrobe),
        .regRdData(regRdData), .profileSelect(profileSelect), .keyingInputPin(keyingInputPin),
        .syncIn(syncIn), .outputAmplitudeScale(outputAmplitudeScale), .ampRampRate(ampRampRate),
        .ramSegmentControlWord(ramSegmentControlWord), .ramActive(ramActive),
        .ramToPhase(ramToPhase), .ramToFrequency(ramToFrequency), .activeProfile(activeProfile),
        .outputScalar(outputScalar), .rampTick(rampTick), .syncAlignEnable(syncAlignEnable),
        .syncAlignReq(syncAlignReq), .sweepActive(sweepActive), .sweepDelta(sweepDelta),
        .sweepRate(sweepRate), .phaseOffsetWord(phaseOffsetWord),
        .tuningWordOne(tuningWordOne), .ramMode(ramMode));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (rampTick === 1'b1) ticks++;
        if (syncAlignReq === 1'b1) syncs++;
    end

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic ctrl(input logic [31:0] v);
        i_host.wr(`DMCR_ADDR_CTRL, {8'h00, v});
        i_host.upd();
    endtask
    // A bounded wait, so a scalar that never settles shows as a mismatch.
    task automatic waitScalar(input logic [13:0] t);
        for (int i = 0; i < 400 && outputScalar !== t; i++) @(posedge sys_clk);
        #1;
        chk(outputScalar, t);
    endtask

    initial begin
        #(40 * 20000);
        err_total++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        keyingInputPin = 1'b0;
        syncIn = 1'b0;
        profileSelect = 3'b000;
        outputAmplitudeScale = 14'h0003;
        ampRampRate = 8'h02;
        ramSegmentControlWord = 14'h0002;
        repeat (5) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        // Reset values and unmapped reads.
        i_host.rd(`DMCR_ADDR_CTRL, rdv);
        chk(rdv, 40'h0000000000);
        i_host.rd(`DMCR_ADDR_PHS0, rdv);
        chk(rdv, 40'h0000000000);
        chk({ramActive, phaseOffsetWord, outputScalar}, 31'h00003fff);
        i_host.rd(8'h1f, rdv);
        chk(rdv, 40'h0000000000);
        $display("test reset done");
        // Control bit rows.
        for (int r = 0; r < 5; r++) begin
            ctrl(rowCtrl[r]);
            chk({ramActive, ramToPhase, ramToFrequency, syncAlignEnable, sweepActive, ramMode},
                rowExp[r]);
        end
        $display("test control rows done");
        // Phase word masking and shadowed reads.
        i_host.wr(`DMCR_ADDR_PHS0, 40'h000000ffff);
        i_host.rd(`DMCR_ADDR_PHS0, rdv);
        chk(rdv, 40'h0000003fff);
        chk(phaseOffsetWord, 16'h0000);
        i_host.wr(`DMCR_ADDR_TUN1, 40'h00a5c3e1f7);
        i_host.upd();
        chk({phaseOffsetWord, tuningWordOne}, 48'h3fffa5c3e1f7);
        $display("test phase word done");
        // Sweep words and direction select.
        i_host.wr(`DMCR_ADDR_FALL, 40'h5e12345678);
        i_host.wr(`DMCR_ADDR_RISE, 40'hc98765abcd);
        ctrl(32'h00200000);
        profileSelect = 3'b001;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({sweepDelta, sweepRate}, 40'h8765abcdc9);
        profileSelect = 3'b000;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({sweepDelta, sweepRate}, 40'h123456785e);
        $display("test sweep done");
        // Keying forms.
        ctrl(32'h00000000);
        chk(outputScalar, 14'h3fff);
        ctrl(32'h02000000);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(outputScalar, outputAmplitudeScale);
        ctrl(32'h03000000);
        keyingInputPin = 1'b0;
        waitScalar(14'h0000);
        keyingInputPin = 1'b1;
        waitScalar(14'h0003);
        keyingInputPin = 1'b0;
        waitScalar(14'h0000);
        $display("test keying done");
        // Strobes faster than the ramp period suppress timeouts only with the load bit set.
        ampRampRate = 8'h14;
        for (int m = 0; m < 2; m++) begin
            ctrl(m ? 32'h07000000 : 32'h03000000);
            repeat (30) @(posedge sys_clk);
            #1;
            ticks = 0;
            repeat (12) i_host.upd();
            chk(ticks > 0, m == 0);
        end
        $display("test ramp reload done");
        // Profile looping versus external selects.
        ampRampRate = 8'h02;
        profileSelect = 3'b010;
        ctrl(32'h80000000);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(activeProfile, 2'b10);
        ctrl(32'h88000000);
        for (int i = 0; i < 200 && activeProfile === 2'b10; i++) @(posedge sys_clk);
        #1;
        chk(activeProfile inside {2'b00, 2'b01}, 1'b1);
        $display("test profile loop done");
        // Sync input edges with alignment off, then on.
        for (int m = 0; m < 2; m++) begin
            ctrl(m ? 32'h00800000 : 32'h00000000);
            syncs = 0;
            repeat (3) begin
                @(posedge sys_clk);
                #1;
                syncIn = 1'b1;
                repeat (3) @(posedge sys_clk);
                #1;
                syncIn = 1'b0;
                repeat (2) @(posedge sys_clk);
            end
            chk(syncs, m ? 3 : 0);
        end
        $display("test sync done");
        // A write and a strobe while the clock enable is low must leave no trace.
        #1;
        clkEn = 1'b0;
        ctrl(32'h80000000);
        chk({ramActive, syncAlignEnable}, 2'b01);
        clkEn = 1'b1;
        i_host.rd(`DMCR_ADDR_CTRL, rdv);
        chk(rdv, 40'h0000800000);
        $display("test clock enable done");
        // Reset in mid-run clears the committed control word.
        @(posedge sys_clk);
        #1;
        rst = 1'b1;
        @(posedge sys_clk);
        #1;
        rst = 1'b0;
        chk({ramActive, syncAlignEnable, outputScalar}, 16'h0000);
        @(posedge sys_clk);
        #1;
        chk(outputScalar, 14'h3fff);
        $display("test second reset done");
        close_out();
    end
endmodule

// ### dmcr_pkg.sv
// Types shared by the mode control bank.
// Assumes the constants header for numeric values.
package dmcr_pkg;
    typedef enum logic [2:0] {
        DMCR_KEY_OFF    = 3'b001,
        DMCR_KEY_MANUAL = 3'b010,
        DMCR_KEY_AUTO   = 3'b100
    } dmcr_key_t;
    typedef enum logic [1:0] {
        DMCR_SRC_TONE = 2'b01,
        DMCR_SRC_RAM  = 2'b10
    } dmcr_src_t;
endpackage

// ### dmcr_ramp_keyer.sv
// Amplitude ramp timer and shaped on-off keying scalar.
// Assumes the scale and rate come straight from input ports of the bank.
`timescale 1ns/1ps
`include "dmcr_consts.svh"
module dmcr_ramp_keyer (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 clkEn,
    input  wire dmcr_pkg::dmcr_key_t  keyMode,
    input  wire logic                 reloadOnUpdate,
    input  wire logic                 updateStrobe,
    input  wire logic                 keyingInputPin,
    input  wire logic [13:0]          outputAmplitudeScale,
    input  wire logic [7:0]           rampRate,
    output logic [13:0]               outputScalar,
    output logic                      rampTick
);
    logic [7:0] timer;
    logic       timeout;

    assign timeout = (timer <= 8'h01);
    assign rampTick = timeout;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer <= 8'h00;
        end else if (clkEn) begin
            if (timeout || (reloadOnUpdate && updateStrobe)) begin
                timer <= rampRate;
            end else begin
                timer <= timer - 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            outputScalar <= 14'h0000;
        end else if (clkEn) begin
            case (keyMode)
                dmcr_pkg::DMCR_KEY_OFF:    outputScalar <= 14'h3fff;
                dmcr_pkg::DMCR_KEY_MANUAL: outputScalar <= outputAmplitudeScale;
                dmcr_pkg::DMCR_KEY_AUTO: begin
                    if (timeout) begin
                        if (keyingInputPin && outputScalar < outputAmplitudeScale) begin
                            outputScalar <= outputScalar + 14'h0001;
                        end else if (!keyingInputPin && outputScalar != 14'h0000) begin
                            outputScalar <= outputScalar - 14'h0001;
                        end else if (outputScalar > outputAmplitudeScale) begin
                            outputScalar <= outputAmplitudeScale;
                        end
                    end
                end
                default: outputScalar <= 14'h0000;
            endcase
        end
    end

    property p_ramp_bounded;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && keyMode == dmcr_pkg::DMCR_KEY_AUTO && $past(keyMode) ==
            dmcr_pkg::DMCR_KEY_AUTO && $stable(outputAmplitudeScale) &&
            $past(outputScalar) <= outputAmplitudeScale)
            |-> outputScalar <= outputAmplitudeScale;
    endproperty
    a_ramp_bounded: assert property (p_ramp_bounded) else $error("scalar over scale");
    property p_ramp_down;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && keyMode == dmcr_pkg::DMCR_KEY_AUTO && !keyingInputPin && timeout &&
            outputScalar != 14'h0000) |=> (outputScalar == $past(outputScalar) - 14'h0001);
    endproperty
    a_ramp_down: assert property (p_ramp_down) else $error("no ramp down");
    property p_reload_update;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && reloadOnUpdate && updateStrobe) |=> timer == $past(rampRate);
    endproperty
    a_reload_update: assert property (p_reload_update) else $error("no reload");
    property p_no_reload;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && !reloadOnUpdate && !timeout) |=> timer == $past(timer) - 8'h01;
    endproperty
    a_no_reload: assert property (p_no_reload) else $error("bad reload");
endmodule
